// ==== logic/nbcp_defines.svh ====
// Offsets, constants and field layout of the boot configuration image
`ifndef NBCP_DEFINES_SVH
`define NBCP_DEFINES_SVH
`define NBCP_OFF_CHECKSUM 10'h000
`define NBCP_OFF_FINGERPRINT 10'h004
`define NBCP_OFF_VERSION 10'h008
`define NBCP_OFF_SEARCH_PAGE 10'h00C
`define NBCP_OFF_STRIDE 10'h010
`define NBCP_OFF_COPY_TOTAL 10'h012
`define NBCP_OFF_IMAGE_COPIES 10'h014
`define NBCP_OFF_TABLE 10'h040
`define NBCP_OFF_PARAM 10'h100
`define NBCP_IMAGE_BYTES 11'h400
`define NBCP_PARAM_BYTES 10'h100
`define NBCP_TABLE_ENTRIES 4'h8
`define NBCP_TABLE_ENTRY_BYTES 10'h008
`define NBCP_FINGERPRINT_VALUE 32'h4E464342
`define NBCP_VERSION_VALUE 32'h00000001
`define NBCP_COPIES_MIN 32'h00000001
`define NBCP_COPIES_MAX 32'h00000008
`define NBCP_P_VERSION 10'h004
`define NBCP_P_MEM_KIND 10'h008
`define NBCP_P_ACCESS 10'h009
`define NBCP_P_CLOCK 10'h00C
`define NBCP_P_BUS_WAIT 10'h00D
`define NBCP_P_CMD_WAIT 10'h00E
`define NBCP_P_STROBE 10'h00F
`define NBCP_P_WIN_BASE 10'h010
`define NBCP_P_WIN_SIZE 10'h014
`define NBCP_P_CMD_BASE 10'h018
`define NBCP_MEM_KIND_PARALLEL 8'h01
`define NBCP_WAIT_UNIT_SHIFT 10
`define NBCP_WAIT_ZERO_VALUE 8'hFF
`define NBCP_REG_CTRL 12'h000
`define NBCP_REG_STATUS 12'h004
`define NBCP_REG_BASE 12'h008
`define NBCP_REG_SETTINGS 12'h00C
`define NBCP_REG_WIN_BASE 12'h010
`define NBCP_REG_WIN_SIZE 12'h014
`define NBCP_REG_CMD_BASE 12'h018
`define NBCP_REG_STRIDE 12'h01C
`define NBCP_REG_VERSION 12'h020
`define NBCP_REG_BUS_WAIT 12'h024
`define NBCP_REG_CMD_WAIT 12'h028
`define NBCP_REG_COPIES 12'h02C
`define NBCP_REG_TABLE 12'h040
`endif

// ==== logic/nbcp_pkg.sv ====
// Types shared by the boot configuration parser
package nbcp_pkg;
  typedef enum logic [1:0] {
    NBCP_PATH_IP_CMD,
    NBCP_PATH_MAPPED,
    NBCP_PATH_BAD
  } nbcp_path_t;
  typedef enum logic [3:0] {
    NBCP_CLK_33, NBCP_CLK_40, NBCP_CLK_50, NBCP_CLK_66,
    NBCP_CLK_108, NBCP_CLK_133, NBCP_CLK_166, NBCP_CLK_MAX,
    NBCP_CLK_BAD
  } nbcp_clock_t;
endpackage

// ==== logic/nbcp_table_mem.sv ====
// Small memory holding the image location table words
`timescale 1ns/1ps
module nbcp_table_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk_i,
  input wire logic clk_en_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [31:0] rd_data_o
);
  logic [31:0] mem [DEPTH];
  // No reset on the array or on the read data register, which loads every enabled cycle
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // nbcp_table_mem

// ==== logic/nbcp_parser.sv ====
// Boot configuration image parser with APB registers and memory reader
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "nbcp_defines.svh"
module nbcp_parser #(
  parameter int ADDR_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic mem_req_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_data_i,
  output logic cfg_valid_o,
  output logic cfg_path_mapped_o,
  output logic [3:0] cfg_clock_code_o,
  output logic cfg_strobe_pad_o,
  output logic [17:0] cfg_bus_wait_o,
  output logic [17:0] cfg_cmd_wait_o,
  output logic [31:0] cfg_win_base_o,
  output logic [31:0] cfg_win_size_o,
  output logic [31:0] cfg_cmd_base_o
);
  import nbcp_pkg::*;

  typedef enum logic [1:0] {NBCP_IDLE, NBCP_REQ, NBCP_CHECK} nbcp_state_t;

  // Decoded parameter block and table ranges share one compare
  function automatic logic at(input logic [9:0] ofs, input logic [9:0] base,
                              input logic [9:0] len);
    at = (ofs >= base) && (ofs < base + len);
  endfunction

  nbcp_state_t state_reg, state_next;
  logic [9:0] ofs_reg;
  logic [ADDR_W-1:0] base_reg;
  logic busy_reg, done_reg, err_fmt_reg, err_kind_reg, err_copies_reg;
  logic [31:0] shift_reg;
  logic [31:0] fingerprint_reg, version_reg, copies_reg, checksum_reg;
  logic [31:0] pversion_reg, win_base_reg, win_size_reg, cmd_base_reg;
  logic [15:0] stride_reg, copy_total_reg;
  logic [7:0] kind_reg, access_reg, clock_reg, bus_wait_reg, cmd_wait_reg;
  logic [7:0] strobe_reg;
  logic [31:0] table_rd;

  // APB decode
  wire apb_setup = psel_i && !penable_i;
  wire apb_write = pready_o && pwrite_i;
  wire [11:0] word_addr = {paddr_i[11:2], 2'b00};
  wire start = apb_write && (word_addr == `NBCP_REG_CTRL) && pwdata_i[0]
               && !busy_reg;
  wire base_wr = apb_write && (word_addr == `NBCP_REG_BASE) && !busy_reg;
  wire is_table = (word_addr >= `NBCP_REG_TABLE) &&
                  (word_addr < `NBCP_REG_TABLE + 12'h040);
  wire [3:0] table_rd_idx = paddr_i[5:2];

  // Memory reader: bytes come little-endian, assembled per word
  wire byte_in = clk_en_i && (state_reg == NBCP_REQ) && mem_ack_i;
  wire [31:0] word_now = {mem_data_i, shift_reg[31:8]};
  wire word_end = byte_in && (ofs_reg[1:0] == 2'b11);
  wire [15:0] half_now = {mem_data_i, shift_reg[31:24]};
  wire half_end = byte_in && (ofs_reg[0] == 1'b1);
  wire last_byte = byte_in &&
                   ({1'b0, ofs_reg} == `NBCP_IMAGE_BYTES - 11'h001);
  wire [9:0] pofs = ofs_reg - `NBCP_OFF_PARAM;
  wire in_param = at(ofs_reg, `NBCP_OFF_PARAM, `NBCP_PARAM_BYTES);
  wire in_table = at(ofs_reg, `NBCP_OFF_TABLE,
                     {6'h00, `NBCP_TABLE_ENTRIES} * `NBCP_TABLE_ENTRY_BYTES);
  wire table_wr = word_end && in_table;
  wire [3:0] table_wr_idx = ofs_reg[5:2];
  wire pbyte = byte_in && in_param;

  // Validity checks on the stored image words
  wire fp_ok = fingerprint_reg == `NBCP_FINGERPRINT_VALUE;
  wire ver_ok = version_reg == `NBCP_VERSION_VALUE;
  wire copies_ok = (copies_reg >= `NBCP_COPIES_MIN) &&
                   (copies_reg <= `NBCP_COPIES_MAX);
  wire kind_ok = kind_reg == `NBCP_MEM_KIND_PARALLEL;
  wire image_ok = fp_ok && ver_ok && copies_ok && kind_ok;

  // Wait limit decode shared by both timeouts
  function automatic logic [17:0] wait_cycles(input logic [7:0] n);
    logic [7:0] v;
    v = (n == 8'h00) ? `NBCP_WAIT_ZERO_VALUE : n;
    wait_cycles = {v, {`NBCP_WAIT_UNIT_SHIFT{1'b0}}};
  endfunction

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      NBCP_IDLE: if (start) state_next = NBCP_REQ;
      NBCP_REQ: if (last_byte) state_next = NBCP_CHECK;
      NBCP_CHECK: state_next = NBCP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= NBCP_IDLE;
      ofs_reg <= 10'h000;
      busy_reg <= 1'b0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      busy_reg <= (state_next != NBCP_IDLE);
      if (start) begin
        ofs_reg <= 10'h000;
      end else if (byte_in) begin
        ofs_reg <= ofs_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      base_reg <= '0;
      shift_reg <= 32'h00000000;
    end else if (clk_en_i) begin
      if (base_wr) begin
        base_reg <= pwdata_i[ADDR_W-1:0];
      end
      if (byte_in) begin
        shift_reg <= word_now;
      end
    end
  end

  // Header words of the outer image
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      checksum_reg <= 32'h00000000;
      fingerprint_reg <= 32'h00000000;
      version_reg <= 32'h00000000;
      copies_reg <= 32'h00000000;
      stride_reg <= 16'h0000;
      copy_total_reg <= 16'h0000;
    end else if (clk_en_i) begin
      if (word_end && {ofs_reg[9:2], 2'b00} == `NBCP_OFF_CHECKSUM) begin
        checksum_reg <= word_now;
      end
      if (word_end && {ofs_reg[9:2], 2'b00} == `NBCP_OFF_FINGERPRINT) begin
        fingerprint_reg <= word_now;
      end
      if (word_end && {ofs_reg[9:2], 2'b00} == `NBCP_OFF_VERSION) begin
        version_reg <= word_now;
      end
      if (word_end && {ofs_reg[9:2], 2'b00} == `NBCP_OFF_IMAGE_COPIES) begin
        copies_reg <= word_now;
      end
      if (half_end && {ofs_reg[9:1], 1'b0} == `NBCP_OFF_STRIDE) begin
        stride_reg <= half_now;
      end
      if (half_end && {ofs_reg[9:1], 1'b0} == `NBCP_OFF_COPY_TOTAL) begin
        copy_total_reg <= half_now;
      end
    end
  end

  // Parameter block fields, offsets relative to its start
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pversion_reg <= 32'h00000000;
      win_base_reg <= 32'h00000000;
      win_size_reg <= 32'h00000000;
      cmd_base_reg <= 32'h00000000;
      kind_reg <= 8'h00;
      access_reg <= 8'h00;
      clock_reg <= 8'h00;
      bus_wait_reg <= 8'h00;
      cmd_wait_reg <= 8'h00;
      strobe_reg <= 8'h00;
    end else if (clk_en_i && pbyte) begin
      if (pofs[1:0] == 2'b11 && {pofs[9:2], 2'b00} == `NBCP_P_VERSION)
        pversion_reg <= word_now;
      if (pofs[1:0] == 2'b11 && {pofs[9:2], 2'b00} == `NBCP_P_WIN_BASE)
        win_base_reg <= word_now;
      if (pofs[1:0] == 2'b11 && {pofs[9:2], 2'b00} == `NBCP_P_WIN_SIZE)
        win_size_reg <= word_now;
      if (pofs[1:0] == 2'b11 && {pofs[9:2], 2'b00} == `NBCP_P_CMD_BASE)
        cmd_base_reg <= word_now;
      if (pofs == `NBCP_P_MEM_KIND) kind_reg <= mem_data_i;
      if (pofs == `NBCP_P_ACCESS) access_reg <= mem_data_i;
      if (pofs == `NBCP_P_CLOCK) clock_reg <= mem_data_i;
      if (pofs == `NBCP_P_BUS_WAIT) bus_wait_reg <= mem_data_i;
      if (pofs == `NBCP_P_CMD_WAIT) cmd_wait_reg <= mem_data_i;
      if (pofs == `NBCP_P_STROBE) strobe_reg <= mem_data_i;
    end
  end

  nbcp_table_mem #(.DEPTH(16), .AW(4)) u_table (
    .sys_clk_i(sys_clk_i),
    .clk_en_i(clk_en_i),
    .wr_en_i(table_wr),
    .wr_addr_i(table_wr_idx),
    .wr_data_i(word_now),
    .rd_addr_i(table_rd_idx),
    .rd_data_o(table_rd)
  );

  // Decoded settings; unknown access and clock codes map to a bad value
  wire path_known = access_reg[7:1] == 7'h00;
  wire clock_known = clock_reg[7:3] == 5'h00;
  wire strobe_known = strobe_reg[7:1] == 7'h00;
  nbcp_path_t path_dec;
  nbcp_clock_t clock_dec;
  assign path_dec = !path_known ? NBCP_PATH_BAD :
                    access_reg[0] ? NBCP_PATH_MAPPED : NBCP_PATH_IP_CMD;
  assign clock_dec = clock_known ? nbcp_clock_t'({1'b0, clock_reg[2:0]})
                                 : NBCP_CLK_BAD;
  wire settings_ok = image_ok && path_known && clock_known && strobe_known;

  // Settings reach the controller only after a clean check
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      done_reg <= 1'b0;
      err_fmt_reg <= 1'b0;
      err_kind_reg <= 1'b0;
      err_copies_reg <= 1'b0;
      cfg_valid_o <= 1'b0;
      cfg_path_mapped_o <= 1'b0;
      cfg_clock_code_o <= 4'h0;
      cfg_strobe_pad_o <= 1'b0;
      cfg_bus_wait_o <= 18'h00000;
      cfg_cmd_wait_o <= 18'h00000;
      cfg_win_base_o <= 32'h00000000;
      cfg_win_size_o <= 32'h00000000;
      cfg_cmd_base_o <= 32'h00000000;
    end else if (clk_en_i) begin
      if (start) begin
        done_reg <= 1'b0;
        cfg_valid_o <= 1'b0;
      end else if (state_reg == NBCP_CHECK) begin
        done_reg <= 1'b1;
        err_fmt_reg <= !(fp_ok && ver_ok);
        err_copies_reg <= !copies_ok;
        err_kind_reg <= !kind_ok ||
                        !(path_known && clock_known && strobe_known);
        cfg_valid_o <= settings_ok;
        if (settings_ok) begin
          cfg_path_mapped_o <= (path_dec == NBCP_PATH_MAPPED);
          cfg_clock_code_o <= clock_dec;
          cfg_strobe_pad_o <= strobe_reg[0];
          cfg_bus_wait_o <= wait_cycles(bus_wait_reg);
          cfg_cmd_wait_o <= wait_cycles(cmd_wait_reg);
          cfg_win_base_o <= win_base_reg;
          cfg_win_size_o <= win_size_reg;
          cfg_cmd_base_o <= cmd_base_reg;
        end
      end
    end
  end

  // Memory address: byte address from base plus running offset
  assign mem_req_o = (state_reg == NBCP_REQ);
  assign mem_addr_o = base_reg + {{(ADDR_W-10){1'b0}}, ofs_reg};

  // APB read mux; table entries beyond the image copies count read as zero
  wire [3:0] entry_idx = table_rd_idx >> 1;
  wire entry_used = {28'h0000000, entry_idx} < copies_reg;
  logic [31:0] rd_mux;
  logic rd_bad;
  always_comb begin
    rd_mux = 32'h00000000;
    rd_bad = 1'b0;
    if (is_table) begin
      rd_mux = entry_used ? table_rd : 32'h00000000;
    end else begin
      unique case (word_addr)
        `NBCP_REG_CTRL: rd_mux = {31'h00000000, busy_reg};
        `NBCP_REG_STATUS: rd_mux = {27'h0000000, err_kind_reg,
                                    err_copies_reg, err_fmt_reg,
                                    cfg_valid_o, done_reg};
        `NBCP_REG_BASE: rd_mux = {{(32-ADDR_W){1'b0}}, base_reg};
        `NBCP_REG_SETTINGS: rd_mux = {16'h0000, strobe_reg, clock_reg[3:0],
                                      2'b00, path_dec};
        `NBCP_REG_WIN_BASE: rd_mux = win_base_reg;
        `NBCP_REG_WIN_SIZE: rd_mux = win_size_reg;
        `NBCP_REG_CMD_BASE: rd_mux = cmd_base_reg;
        `NBCP_REG_STRIDE: rd_mux = {copy_total_reg, stride_reg};
        `NBCP_REG_VERSION: rd_mux = pversion_reg;
        `NBCP_REG_BUS_WAIT: rd_mux = {24'h000000, bus_wait_reg};
        `NBCP_REG_CMD_WAIT: rd_mux = {24'h000000, cmd_wait_reg};
        `NBCP_REG_COPIES: rd_mux = copies_reg;
        default: rd_bad = 1'b1;
      endcase
    end
  end

  // Access phase waits one cycle so the table memory read settles
  logic wait_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wait_reg <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      wait_reg <= apb_setup;
      // Loaded in the wait cycle so it stands when pready is high
      if (psel_i && penable_i && !pwrite_i && wait_reg) begin
        prdata_o <= rd_mux;
      end
    end
  end
  assign pready_o = psel_i && penable_i && !wait_reg && clk_en_i;
  assign pslverr_o = pready_o && rd_bad;
endmodule // nbcp_parser

// ==== tb/nbcp_parser_assertions.sv ====
// Port-level checks of the boot configuration parser
`timescale 1ns/1ps
module nbcp_parser_assertions #(
  parameter int ADDR_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic mem_req_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic cfg_valid_o,
  input wire logic [3:0] cfg_clock_code_o,
  input wire logic [17:0] cfg_bus_wait_o,
  input wire logic [17:0] cfg_cmd_wait_o,
  input wire logic [31:0] cfg_win_base_o
);
  logic [2:0] idle_cnt;
  logic [10:0] ack_cnt;
  // The window base may only move while a read runs or in the seven cycles after it ends
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || mem_req_o) idle_cnt <= 3'h0;
    else if (idle_cnt != 3'h7) idle_cnt <= idle_cnt + 3'h1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !mem_req_o) ack_cnt <= 11'h000;
    else if (mem_ack_i && clk_en_i) ack_cnt <= ack_cnt + 11'h001;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ready_wait: assert property ($rose(penable_i) && psel_i && clk_en_i
    |-> !pready_o ##1 pready_o) else $error("pready timing wrong");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (psel_i && penable_i && pready_o &&
    paddr_i >= 12'h080 |-> pslverr_o) else $error("unmapped not refused");
  chk_addr_step: assert property (
    mem_req_o && mem_ack_i && clk_en_i ##1 mem_req_o
    |-> mem_addr_o == $past(mem_addr_o) + 1'b1)
    else $error("address did not advance");
  chk_addr_hold: assert property (
    mem_req_o && !(mem_ack_i && clk_en_i) ##1 mem_req_o
    |-> $stable(mem_addr_o))
    else $error("address moved without ack");
  chk_read_length: assert property (
    $fell(mem_req_o) |-> ack_cnt == 11'h400)
    else $error("image read not 1024 bytes");
  chk_bus_units: assert property (cfg_valid_o |->
    cfg_bus_wait_o[9:0] == 10'h000 && cfg_bus_wait_o != 18'h00000)
    else $error("bus wait not whole units");
  chk_cmd_units: assert property (cfg_valid_o |->
    cfg_cmd_wait_o[9:0] == 10'h000 && cfg_cmd_wait_o != 18'h00000)
    else $error("command wait not whole units");
  chk_clock_range: assert property (
    cfg_valid_o |-> cfg_clock_code_o <= 4'h7)
    else $error("clock code out of range");
  chk_cfg_quiet: assert property (
    idle_cnt == 3'h7 |-> $stable(cfg_win_base_o))
    else $error("settings changed while idle");
  cover property (mem_req_o && mem_ack_i);
  cover property ($rose(cfg_valid_o));
  cover property (pslverr_o);
endmodule // nbcp_parser_assertions

bind nbcp_parser nbcp_parser_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk_i, .reset_n_i, .clk_en_i, .psel_i, .penable_i, .paddr_i,
  .pready_o, .pslverr_o, .mem_req_o, .mem_addr_o, .mem_ack_i,
  .cfg_valid_o, .cfg_clock_code_o, .cfg_bus_wait_o, .cfg_cmd_wait_o,
  .cfg_win_base_o);

// ==== tb/nbcp_image_mem.sv ====
// Byte memory holding the configuration image, optionally slow
`timescale 1ns/1ps
module nbcp_image_mem #(
  parameter logic [31:0] BASE = 32'h00010000
) (
  input wire logic sys_clk_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic [7:0] data_o
);
  logic [7:0] img [0:1023];
  logic [7:0] last = 8'h00;
  logic phase = 1'b0;
  logic [31:0] off;
  logic [31:0] first = 32'h0;
  int unsigned cnt = 0;
  assign off = addr_i - BASE;
  assign ack_o = req_i && (!slow_i || phase);
  // Outside a transfer the byte lane shows junk, never the last byte
  assign data_o = ack_o ? img[off[9:0]] : ~last;
  always @(posedge sys_clk_i) begin
    phase <= ~phase;
    if (ack_o) begin
      last <= data_o;
      if (cnt == 0) first <= addr_i;
      cnt <= cnt + 1;
    end
  end
endmodule // nbcp_image_mem

// ==== tb/nbcp_parser_tb_top.sv ====
// Self-checking bench of the boot configuration parser
`timescale 1ns/1ps
module nbcp_parser_tb_top;
  localparam logic [31:0] BASE = 32'h00010000;
  localparam logic [31:0] WB = 32'h60000000;
  localparam logic [31:0] FP = 32'h4E464342;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic cen = 1'b1;
  logic [31:0] prdata, maddr, rd, wbase, wsize, cbase;
  logic pready, pslverr, req, ack, valid, path, strobe, er;
  logic [7:0] mdata;
  logic [3:0] ccode;
  logic [17:0] bwait, cwait;
  int failures = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  nbcp_parser dut (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(cen),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mem_req_o(req),
    .mem_addr_o(maddr), .mem_ack_i(ack), .mem_data_i(mdata),
    .cfg_valid_o(valid), .cfg_path_mapped_o(path),
    .cfg_clock_code_o(ccode), .cfg_strobe_pad_o(strobe),
    .cfg_bus_wait_o(bwait), .cfg_cmd_wait_o(cwait),
    .cfg_win_base_o(wbase), .cfg_win_size_o(wsize),
    .cfg_cmd_base_o(cbase));
  nbcp_image_mem #(.BASE(BASE)) mem (.sys_clk_i(clk), .req_i(req),
    .addr_i(maddr), .slow_i(slow), .ack_o(ack), .data_o(mdata));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "register read");
  endtask
  task automatic pw(input int o, input logic [31:0] v);
    for (int i = 0; i < 4; i++) mem.img[o+i] = v[8*i+:8];
  endtask
  task automatic mk(input logic [31:0] fp, ver, cp, wb,
                    input logic [7:0] kd, pa, input logic [31:0] w);
    for (int i = 0; i < 1024; i++) mem.img[i] = 8'h00;
    pw(4, fp);
    pw(8, ver);
    pw('h10, 32'h00030005);
    pw('h14, cp);
    for (int i = 0; i < 8; i++) begin
      pw('h40 + 8 * i, 32'h100 * (i + 1));
      pw('h44 + 8 * i, i + 1);
    end
    pw('h104, 32'h00010203);
    pw('h108, {16'h0, pa, kd});
    pw('h10C, w);
    pw('h110, wb);
    pw('h114, 32'h00100000);
    pw('h118, 32'h40000000);
  endtask
  task automatic run_img();
    int n;
    mem.cnt = 0;
    apb(1'b1, 12'h008, BASE);
    apb(1'b1, 12'h000, 32'h1);
    n = 0;
    do begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (n == 2000) failures++;
    chk(mem.cnt, 32'h400, "bytes read");
    chk(mem.first, BASE, "first address");
  endtask
  task automatic t_reset();
    chk(valid, 1'b0, "valid after reset");
    chk(req, 1'b0, "req after reset");
    rchk(12'h004, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_settings();
    for (int c = 0; c < 8; c++) begin
      slow <= c[2];
      mk(FP, 1, 2, WB, 1, 8'(c[0]), {7'h0, c[1], 8'(7 - c), 8'(c), 8'(c)});
      run_img();
      chk(valid, 1'b1, "valid");
      chk(path, c[0], "path");
      chk(ccode, c, "clock code");
      chk(strobe, c[1], "strobe");
      chk(bwait, (c == 0 ? 255 : c) * 1024, "bus wait");
      chk(cwait, (c == 7 ? 255 : 7 - c) * 1024, "cmd wait");
      chk(wbase, WB, "window base");
      chk(wsize, 32'h00100000, "window size");
      chk(cbase, 32'h40000000, "command base");
    end
    $display("test settings done");
  endtask
  task automatic t_regs();
    rchk(12'h00C, 32'h00000171);
    rchk(12'h01C, 32'h00030005);
    rchk(12'h020, 32'h00010203);
    rchk(12'h024, 32'h7);
    rchk(12'h028, 32'h0);
    rchk(12'h02C, 32'h2);
    for (int i = 0; i < 4; i++) begin
      rchk(12'h040 + 12'(8 * i), i < 2 ? 32'h100 * (i + 1) : 0);
      rchk(12'h044 + 12'(8 * i), i < 2 ? i + 1 : 0);
    end
    $display("test registers done");
  endtask
  task automatic t_errors();
    logic [31:0] fp [6] = '{32'h4E464343, FP, FP, FP, FP, FP};
    logic [31:0] ve [6] = '{1, 2, 1, 1, 1, 1};
    logic [31:0] cp [6] = '{2, 2, 0, 9, 2, 8};
    logic [7:0] kd [6] = '{1, 1, 1, 1, 2, 1};
    logic [3:0] eb [6] = '{4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h1};
    slow <= 1'b0;
    // The failing images carry another window base: it must not land
    for (int i = 0; i < 6; i++) begin
      mk(fp[i], ve[i], cp[i], 32'h70000000, kd[i], 1, 32'h01000005);
      run_img();
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[4:1], eb[i], "status");
      chk(valid, eb[i] == 4'h1, "valid");
      chk(wbase, i == 5 ? 32'h70000000 : WB, "kept base");
    end
    $display("test errors done");
  endtask
  task automatic t_freeze();
    logic [31:0] a;
    int n;
    mk(FP, 1, 2, WB, 1, 1, 32'h01000005);
    apb(1'b1, 12'h000, 32'h1);
    repeat (20) @(posedge clk);
    cen <= 1'b0;
    @(posedge clk);
    a = maddr;
    repeat (10) @(posedge clk);
    chk(maddr, a, "address held while frozen");
    chk(req, 1'b1, "request held while frozen");
    cen <= 1'b1;
    n = 0;
    do begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (n == 2000) failures++;
    chk(valid, 1'b1, "valid after freeze");
    chk(wbase, WB, "base after freeze");
    $display("test freeze done");
  endtask
  task automatic t_bus();
    apb(1'b0, 12'h080, 32'h0);
    chk(er, 1'b1, "unmapped read");
    apb(1'b1, 12'h030, 32'h5);
    chk(er, 1'b1, "unmapped write");
    apb(1'b0, 12'h02C, 32'h0);
    chk(er, 1'b0, "mapped read");
    $display("test bus done");
  endtask
  initial begin
    #5_000_000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_settings();
    t_regs();
    t_errors();
    t_freeze();
    t_bus();
    complete_run();
  end
endmodule // nbcp_parser_tb_top
